// >>> hdl/flash_seq_pkg.sv
// Purpose: constants for the flash program/erase host sequencer
// Assumes: 10 MHz core clock, byte-wide flash with 17 address bits
// Notes: all times are kept in their printed unit, cycles are derived
package flash_seq_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned ADDR_W = 17;
    localparam int unsigned DATA_W = 8;
    localparam logic [16:0] ADDR_FIRST = 17'h00000;
    localparam logic [16:0] ADDR_LAST = 17'h1ffff;
    // command codes
    localparam logic [7:0] CMD_READ = 8'h00;
    localparam logic [7:0] CMD_ERASE = 8'h20;
    localparam logic [7:0] CMD_ERASE_VERIFY = 8'ha0;
    localparam logic [7:0] CMD_PROGRAM = 8'h40;
    localparam logic [7:0] CMD_PROGRAM_VERIFY = 8'hc0;
    localparam logic [7:0] CMD_ABORT = 8'hff;
    localparam logic [7:0] DATA_ERASED = 8'hff;
    localparam logic [7:0] DATA_CHARGED = 8'h00;
    localparam logic [4:0] PROGRAM_TRIES_MAX = 5'h19;
    // pulse times, least times round up
    localparam int unsigned PROGRAM_PULSE_US = 10;
    localparam int unsigned ERASE_PULSE_MS = 10;
    localparam int unsigned PROGRAM_PULSE_CYC = (PROGRAM_PULSE_US * (CLK_HZ / 1000) + 999) / 1000;
    localparam int unsigned ERASE_PULSE_CYC = (ERASE_PULSE_MS * (CLK_HZ / 1000));
    // bus cycle strobe end counts, one below the strobe length in core clocks
    localparam logic [1:0] PHASE_CYC = 2'h2;
    localparam logic [1:0] READ_CYC = 2'h3;
    // job codes
    localparam logic [1:0] JOB_PROGRAM = 2'h0;
    localparam logic [1:0] JOB_ERASE = 2'h1;
    localparam logic [1:0] JOB_ABORT = 2'h2;
    localparam logic [1:0] JOB_READ = 2'h3;
    localparam logic [1:0] ST_OK = 2'h0;
    localparam logic [1:0] ST_FAIL = 2'h1;
    localparam logic [1:0] ST_ABORTED = 2'h2;
endpackage

// >>> hdl/flash_bus_cycle.sv
// Purpose: one asynchronous flash bus cycle, write or read
// Assumes: inputs are synchronous to core_clk
// Notes: address is set before the write strobe falls, data held past its rise
`timescale 1ns/1ns
module flash_bus_cycle (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // request
    input wire logic start,
    input wire logic is_write,
    input wire logic [16:0] addr,
    input wire logic [7:0] wdata,
    output logic done,
    output logic [7:0] rdata,
    // flash pins
    output logic [16:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [7:0] fl_dq_i
);
    typedef enum logic [2:0] {B_IDLE = 3'b000, B_SETUP = 3'b001, B_STROBE = 3'b011, B_HOLD = 3'b010} bus_st_t;
    bus_st_t st_q;
    logic [1:0] cnt_q;
    logic wr_q;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= B_IDLE;
            cnt_q <= 2'h0;
            wr_q <= 1'b0;
            done <= 1'b0;
            rdata <= 8'h00;
            fl_addr <= 17'h00000;
            fl_ce_n <= 1'b1;
            fl_we_n <= 1'b1;
            fl_oe_n <= 1'b1;
            fl_dq_o <= 8'h00;
            fl_dq_oe <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (st_q)
                B_IDLE: begin
                    if (start) begin
                        // address first so it is stable at the falling strobe
                        fl_addr <= addr;
                        fl_dq_o <= wdata;
                        fl_dq_oe <= is_write;
                        fl_ce_n <= 1'b0;
                        wr_q <= is_write;
                        cnt_q <= 2'h0;
                        st_q <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    if (wr_q) begin
                        fl_we_n <= 1'b0;
                    end else begin
                        fl_oe_n <= 1'b0;
                    end
                    cnt_q <= 2'h0;
                    st_q <= B_STROBE;
                end
                B_STROBE: begin
                    cnt_q <= cnt_q + 2'h1;
                    if (cnt_q == (wr_q ? flash_seq_pkg::PHASE_CYC : flash_seq_pkg::READ_CYC)) begin
                        // rising strobe latches write data
                        fl_we_n <= 1'b1;
                        fl_oe_n <= 1'b1;
                        if (!wr_q) begin
                            rdata <= fl_dq_i;
                        end
                        st_q <= B_HOLD;
                    end
                end
                B_HOLD: begin
                    fl_ce_n <= 1'b1;
                    fl_dq_oe <= 1'b0;
                    done <= 1'b1;
                    st_q <= B_IDLE;
                end
                default: st_q <= B_IDLE;
            endcase
        end
    end
endmodule

// >>> hdl/flash_program_erase_sequence.sv
// Purpose: host sequencer that programs, erases and aborts a byte-wide flash
// Assumes: program supply is on while a job runs; one clock core_clk at 10 MHz
// Notes: a job is started by a one-cycle pulse and ends with done and a status code
// Overview of operation
// RULE_01: after each program pulse write the program-verify code to verify that byte
// RULE_02: device margins the last programmed byte and shows it on a later read
// RULE_03: compare verify read with intended byte, advance only on match
// RULE_04: two back-to-back abort codes after a setup cancel it, array untouched
// RULE_05: after an abort write another valid command, here the read command
// RULE_06: program one byte at a time with a ten microsecond pulse
// RULE_07: at most twenty-five pulse and verify pairs per byte
// RULE_08: erase acts on the whole array at once, address ignored
// RULE_09: erase pulse is ten milliseconds from erase write to erase-verify write
// RULE_10: before erasing, program every byte to zero using the program algorithm
// RULE_11: erase starts by reading the array; all-ones skips the erase
// RULE_12: erase-verify from lowest address up, failure triggers another pulse
// RULE_13: keep last verified address and resume verify there after next pulse
// RULE_14: program verify only after programming; final check uses read command
// RULE_15: erase-verify only after an erase pulse, never after programming
// RULE_16: erase code written twice; erasing runs until the next rising strobe
// RULE_17: after setup-program, next write carries address and data, starts pulse
// RULE_18: every erase-verify byte needs its own command write with its address
// RULE_19: read command returns device to array reads; default after supply up
// RULE_20: a byte failing after the last attempt stops the job with a failure
`timescale 1ns/1ns
module flash_program_erase_sequence #(
    parameter int unsigned ERASE_PULSE_CYCLES = flash_seq_pkg::ERASE_PULSE_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // job request
    input wire logic job_start,
    input wire logic [1:0] job_kind,
    input wire logic [16:0] job_addr,
    input wire logic [7:0] job_data,
    // job answer
    output logic job_busy,
    output logic job_done,
    output logic [1:0] job_status,
    output logic [16:0] fail_addr,
    output logic [7:0] read_data,
    // flash pins
    output logic [16:0] fl_addr,
    output logic fl_ce_n,
    output logic fl_we_n,
    output logic fl_oe_n,
    output logic [7:0] fl_dq_o,
    output logic fl_dq_oe,
    input wire logic [7:0] fl_dq_i
);
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000, S_SETUP = 4'b0001, S_LOAD = 4'b0011, S_PULSE = 4'b0010,
        S_VERIFY = 4'b0110, S_VREAD = 4'b0111, S_CHECK = 4'b0101, S_NEXT = 4'b0100,
        S_ABORT2 = 4'b1100, S_FINISH = 4'b1101, S_SCAN = 4'b1111
    } seq_st_t;
    typedef enum logic [1:0] {PH_CHARGE = 2'b00, PH_ERASE = 2'b01, PH_SINGLE = 2'b11} phase_t;

    seq_st_t st_q;
    phase_t ph_q;
    logic bus_start_q;
    logic bus_write_q;
    logic [16:0] bus_addr_q;
    logic [7:0] bus_data_q;
    logic bus_done;
    logic [7:0] bus_rdata;
    logic [16:0] addr_q;
    logic [16:0] resume_q;
    logic [7:0] target_q;
    logic [4:0] tries_q;
    logic [23:0] wait_q;
    logic [1:0] kind_q;
    logic issued_q;

    flash_bus_cycle u_bus (
        .core_clk(core_clk),
        .rstn(rstn),
        .start(bus_start_q),
        .is_write(bus_write_q),
        .addr(bus_addr_q),
        .wdata(bus_data_q),
        .done(bus_done),
        .rdata(bus_rdata),
        .fl_addr(fl_addr),
        .fl_ce_n(fl_ce_n),
        .fl_we_n(fl_we_n),
        .fl_oe_n(fl_oe_n),
        .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe),
        .fl_dq_i(fl_dq_i)
    );

    // bus cycles run one at a time: issued_q marks that one is under way
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= S_IDLE;
            ph_q <= PH_SINGLE;
            bus_start_q <= 1'b0;
            bus_write_q <= 1'b0;
            bus_addr_q <= 17'h00000;
            bus_data_q <= 8'h00;
            addr_q <= 17'h00000;
            resume_q <= 17'h00000;
            target_q <= 8'h00;
            tries_q <= 5'h00;
            wait_q <= 24'h000000;
            kind_q <= flash_seq_pkg::JOB_READ;
            issued_q <= 1'b0;
            job_busy <= 1'b0;
            job_done <= 1'b0;
            job_status <= flash_seq_pkg::ST_OK;
            fail_addr <= 17'h00000;
            read_data <= 8'h00;
        end else begin
            bus_start_q <= 1'b0;
            job_done <= 1'b0;
            unique case (st_q)
                S_IDLE: begin
                    if (job_start) begin
                        job_busy <= 1'b1;
                        kind_q <= job_kind;
                        issued_q <= 1'b0;
                        tries_q <= 5'h00;
                        unique case (job_kind)
                            flash_seq_pkg::JOB_PROGRAM: begin
                                ph_q <= PH_SINGLE;
                                addr_q <= job_addr;
                                target_q <= job_data;
                                st_q <= S_SETUP;
                            end
                            flash_seq_pkg::JOB_ERASE: begin
                                // check whether the array is already blank first
                                ph_q <= PH_CHARGE;
                                addr_q <= flash_seq_pkg::ADDR_FIRST;
                                target_q <= flash_seq_pkg::DATA_CHARGED;
                                st_q <= S_SCAN; // RULE_11
                            end
                            flash_seq_pkg::JOB_ABORT: begin
                                st_q <= S_ABORT2;
                            end
                            default: begin
                                addr_q <= job_addr;
                                st_q <= S_FINISH;
                            end
                        endcase
                    end
                end
                S_SCAN: begin
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b0;
                        bus_addr_q <= addr_q;
                        issued_q <= 1'b1;
                    end else if (bus_done) begin
                        issued_q <= 1'b0;
                        if (bus_rdata != flash_seq_pkg::DATA_ERASED) begin
                            // not blank: charge every byte to zero before erasing
                            addr_q <= flash_seq_pkg::ADDR_FIRST; // RULE_10
                            st_q <= S_SETUP;
                        end else if (addr_q == flash_seq_pkg::ADDR_LAST) begin
                            st_q <= S_FINISH; // RULE_11
                        end else begin
                            addr_q <= addr_q + 17'h00001;
                        end
                    end
                end
                S_SETUP: begin
                    // setup write: program code, or first erase code
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b1;
                        bus_addr_q <= addr_q;
                        bus_data_q <= (ph_q == PH_ERASE) ? flash_seq_pkg::CMD_ERASE : flash_seq_pkg::CMD_PROGRAM;
                        issued_q <= 1'b1;
                    end else if (bus_done) begin
                        issued_q <= 1'b0;
                        st_q <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    // second write starts the pulse at its rising strobe
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b1;
                        bus_addr_q <= addr_q; // RULE_17
                        bus_data_q <= (ph_q == PH_ERASE) ? flash_seq_pkg::CMD_ERASE : target_q; // RULE_16
                        issued_q <= 1'b1;
                    end else if (bus_done) begin
                        issued_q <= 1'b0;
                        // erase pulses have no limit, so only byte programming counts tries
                        if (ph_q != PH_ERASE) begin
                            tries_q <= tries_q + 5'h01;
                        end
                        wait_q <= (ph_q == PH_ERASE) ? 24'(ERASE_PULSE_CYCLES)
                                                    : 24'(flash_seq_pkg::PROGRAM_PULSE_CYC);
                        st_q <= S_PULSE;
                    end
                end
                S_PULSE: begin
                    // count starts after the load write's hold cycle, so the pulse is never short
                    if (wait_q <= 24'h000001) begin
                        addr_q <= (ph_q == PH_ERASE) ? resume_q : addr_q; // RULE_13
                        st_q <= S_VERIFY; // RULE_06 RULE_09
                    end else begin
                        wait_q <= wait_q - 24'h000001;
                    end
                end
                S_VERIFY: begin
                    // verify write ends the pulse; erase verify carries its address
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b1;
                        bus_addr_q <= addr_q; // RULE_18
                        bus_data_q <= (ph_q == PH_ERASE) ? flash_seq_pkg::CMD_ERASE_VERIFY
                                                        : flash_seq_pkg::CMD_PROGRAM_VERIFY; // RULE_01 RULE_14 RULE_15
                        issued_q <= 1'b1;
                    end else if (bus_done) begin
                        issued_q <= 1'b0;
                        st_q <= S_VREAD;
                    end
                end
                S_VREAD: begin
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b0;
                        bus_addr_q <= addr_q;
                        issued_q <= 1'b1;
                    end else if (bus_done) begin
                        issued_q <= 1'b0;
                        st_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (ph_q == PH_ERASE) begin
                        if (bus_rdata != flash_seq_pkg::DATA_ERASED) begin
                            resume_q <= addr_q; // RULE_12 RULE_13
                            st_q <= S_SETUP;
                        end else if (addr_q == flash_seq_pkg::ADDR_LAST) begin
                            st_q <= S_FINISH;
                        end else begin
                            addr_q <= addr_q + 17'h00001; // RULE_12
                            st_q <= S_VERIFY;
                        end
                    end else if (bus_rdata == target_q) begin
                        st_q <= S_NEXT; // RULE_03
                    end else if (tries_q >= flash_seq_pkg::PROGRAM_TRIES_MAX) begin
                        fail_addr <= addr_q; // RULE_20
                        job_status <= flash_seq_pkg::ST_FAIL;
                        kind_q <= flash_seq_pkg::JOB_READ;
                        st_q <= S_FINISH;
                    end else begin
                        st_q <= S_SETUP; // RULE_07
                    end
                end
                S_NEXT: begin
                    tries_q <= 5'h00;
                    if (ph_q == PH_CHARGE && addr_q != flash_seq_pkg::ADDR_LAST) begin
                        addr_q <= addr_q + 17'h00001;
                        st_q <= S_SETUP;
                    end else if (ph_q == PH_CHARGE) begin
                        // whole array erased together, address is don't-care
                        ph_q <= PH_ERASE; // RULE_08
                        resume_q <= flash_seq_pkg::ADDR_FIRST;
                        addr_q <= flash_seq_pkg::ADDR_FIRST;
                        st_q <= S_SETUP;
                    end else begin
                        st_q <= S_FINISH;
                    end
                end
                S_ABORT2: begin
                    // two abort writes back to back, then read command
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b1;
                        bus_data_q <= flash_seq_pkg::CMD_ABORT; // RULE_04
                        issued_q <= 1'b1;
                    end else if (bus_done) begin
                        issued_q <= 1'b0;
                        tries_q <= tries_q + 5'h01;
                        if (tries_q != 5'h00) begin
                            job_status <= flash_seq_pkg::ST_ABORTED;
                            st_q <= S_FINISH; // RULE_05
                        end
                    end
                end
                S_FINISH: begin
                    // read command leaves the device in array-read mode
                    if (!issued_q) begin
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b1;
                        bus_data_q <= flash_seq_pkg::CMD_READ; // RULE_19 RULE_05
                        issued_q <= 1'b1;
                    end else if (bus_done && kind_q == flash_seq_pkg::JOB_READ && bus_write_q) begin
                        // read job or failed program: follow the command with one array read
                        bus_start_q <= 1'b1;
                        bus_write_q <= 1'b0;
                        bus_addr_q <= addr_q;
                    end else if (bus_done) begin
                        if (!bus_write_q) begin
                            read_data <= bus_rdata;
                        end
                        issued_q <= 1'b0;
                        job_busy <= 1'b0;
                        job_done <= 1'b1;
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
            if (job_start && st_q == S_IDLE) begin
                job_status <= flash_seq_pkg::ST_OK;
            end
        end
    end

    chk_verify_after_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == S_PULSE && wait_q == 24'h000001) |=> st_q == S_VERIFY) // RULE_01
        else $error("pulse end did not go to verify");
    chk_fail_on_tries: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == S_CHECK && ph_q == PH_SINGLE && bus_rdata != target_q && tries_q >= 5'h19)
        |=> job_status == 2'h1) // RULE_20
        else $error("exhausted byte not reported");
    chk_retry_limit: assert property (@(posedge core_clk) disable iff (!rstn)
        tries_q <= 5'h19) // RULE_07
        else $error("too many program attempts");
    chk_match_advance: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == S_CHECK && ph_q != PH_ERASE && bus_rdata == target_q) |=> st_q == S_NEXT) // RULE_03
        else $error("matching byte did not advance");
    chk_erase_miss: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == S_CHECK && ph_q == PH_ERASE && bus_rdata != 8'hff) |=> (st_q == S_SETUP && resume_q == $past(addr_q)))
        // RULE_12
        else $error("erase miss did not repulse");
    chk_pulse_length: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == S_LOAD && bus_done && ph_q == PH_SINGLE) |=> (st_q == S_PULSE) [*8]) // RULE_06
        else $error("program pulse too short");
    chk_abort_pair: assert property (@(posedge core_clk) disable iff (!rstn)
        (st_q == S_ABORT2 && bus_start_q) |-> bus_data_q == 8'hff) // RULE_04
        else $error("abort write carries wrong code");
    chk_done_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        job_done |-> (st_q == S_IDLE && !job_busy)) // RULE_19
        else $error("done while busy");
endmodule

// >>> verification/flash_model.sv
// Purpose: behavioural byte-wide flash with a command register
// Assumes: commands are taken on rising write strobes while chip enable is low
// Notes: programming only clears bits, so a byte that needs a bit set never verifies
`timescale 1ns/1ns
module flash_model (
    // flash pins
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic [16:0] addr,
    input wire logic [7:0] dq,
    input wire logic dq_oe,
    output logic [7:0] dq_i
);
    logic [7:0] mem [int];
    logic [7:0] cmd_q = 8'h00;
    logic [16:0] lat_a, pa_q, ea_q;
    logic [7:0] view = 8'h00;
    logic [7:0] last = 8'h00;
    // 0 idle, 1 setup program, 2 setup erase, 3 pulse running, 4 first abort
    int mode = 0;
    int pulses = 0;
    int bad = 0;
    realtime t0, min_pulse = 1.0e9;
    // an undriven bus shows the opposite of the host value
    wire [7:0] wd = dq_oe ? dq : ~dq;
    function automatic logic [7:0] rd(int a);
        return mem.exists(a) ? mem[a] : 8'hff;
    endfunction
    always @(negedge we_n) if (!ce_n) lat_a = addr;
    always @(posedge we_n) if (!ce_n) begin
        if (mode == 3) begin
            if (wd != 8'hc0 && wd != 8'ha0) bad++;
            if ($realtime - t0 < min_pulse) min_pulse = $realtime - t0;
        end
        if (mode == 1 && wd != 8'hff) begin
            pa_q = lat_a;
            mem[pa_q] = rd(pa_q) & wd;
            pulses++;
            t0 = $realtime;
            mode = 3;
        end else if (mode == 2 && wd == 8'h20) begin
            mem.delete();
            mode = 3;
        end else if ((mode == 1 || mode == 2) && wd == 8'hff) begin
            mode = 4;
        end else if (mode == 4 && wd == 8'hff) begin
            mode = 0;
            cmd_q = 8'hff;
        end else begin
            mode = (wd == 8'h40) ? 1 : (wd == 8'h20) ? 2 : 0;
            cmd_q = wd;
            if (wd == 8'ha0) ea_q = lat_a;
        end
    end
    always @(negedge oe_n) view = (cmd_q == 8'hc0) ? rd(pa_q) : (cmd_q == 8'ha0) ? rd(ea_q) :
        (cmd_q == 8'h00) ? rd(addr) : 8'h5a;
    always @(posedge oe_n) last = view;
    assign dq_i = (!ce_n && !oe_n) ? view : ~last;
endmodule

// >>> verification/test_flash_program_erase_sequence.sv
// Purpose: self-checking bench for the flash host sequencer
// Assumes: a fresh model array reads all ones
// Notes: a full erase is too slow here, so an erase job is cut by a reset once its first charged byte is verified
`timescale 1ns/1ns
module test_flash_program_erase_sequence;
    logic core_clk = 0, rstn = 0, job_start = 0;
    logic [1:0] job_kind = 0;
    logic [16:0] job_addr = 0;
    logic [7:0] job_data = 0;
    logic job_busy, job_done, fl_ce_n, fl_we_n, fl_oe_n, fl_dq_oe;
    logic [1:0] job_status;
    logic [16:0] fail_addr, fl_addr;
    logic [7:0] read_data, fl_dq_o, fl_dq_i;
    logic [7:0] ref_mem [int];
    int failures = 0, checks = 0;
    always #50 core_clk = ~core_clk;
    flash_program_erase_sequence #(.ERASE_PULSE_CYCLES(20)) flash_program_erase_sequence_i (
        .core_clk(core_clk), .rstn(rstn), .job_start(job_start), .job_kind(job_kind),
        .job_addr(job_addr), .job_data(job_data), .job_busy(job_busy), .job_done(job_done),
        .job_status(job_status), .fail_addr(fail_addr), .read_data(read_data), .fl_addr(fl_addr),
        .fl_ce_n(fl_ce_n), .fl_we_n(fl_we_n), .fl_oe_n(fl_oe_n), .fl_dq_o(fl_dq_o),
        .fl_dq_oe(fl_dq_oe), .fl_dq_i(fl_dq_i));
    flash_model flash_model_i (.ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n), .addr(fl_addr),
        .dq(fl_dq_o), .dq_oe(fl_dq_oe), .dq_i(fl_dq_i));
    task check(string what, logic [16:0] seen, logic [16:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // a second start while busy must be ignored
    task run_job(logic [1:0] k, logic [16:0] a, logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        {job_start, job_kind, job_addr, job_data} <= {1'b1, k, a, d};
        @(posedge core_clk);
        job_kind <= flash_seq_pkg::JOB_READ;
        @(posedge core_clk);
        job_start <= 0;
        check("busy", job_busy, 1);
        while (job_done !== 1'b1) begin
            @(negedge core_clk);
            n++;
            if (n > 40000) begin
                failures++;
                finish_test();
            end
        end
        check("idle at done", job_busy, 0);
    endtask
    task read_back(logic [16:0] a);
        run_job(flash_seq_pkg::JOB_READ, a, 8'h00);
        check("read data", read_data, ref_mem.exists(a) ? ref_mem[a] : 8'hff);
    endtask
    task prog(logic [16:0] a, logic [7:0] d);
        logic [7:0] old;
        logic ok;
        int p;
        old = ref_mem.exists(a) ? ref_mem[a] : 8'hff;
        ok = (old & d) == d;
        p = flash_model_i.pulses;
        ref_mem[a] = old & d;
        run_job(flash_seq_pkg::JOB_PROGRAM, a, d);
        check("status", job_status, ok ? flash_seq_pkg::ST_OK : flash_seq_pkg::ST_FAIL);
        check("pulses", flash_model_i.pulses - p, ok ? 1 : 25);
        if (!ok) check("fail addr", fail_addr, a);
        read_back(a);
    endtask
    initial begin
        logic [16:0] a;
        logic [7:0] d;
        int p, n;
        void'($urandom(32'hbbb20e81));
        repeat (20) @(posedge core_clk);
        rstn <= 1;
        a = $urandom_range(15);
        d = $urandom & 8'h7e;
        prog(a, d);
        prog($urandom_range(17'h1ffff, 16), $urandom & 8'h7f);
        prog(a, d | 8'h01);
        run_job(flash_seq_pkg::JOB_ABORT, 0, 0);
        check("abort status", job_status, flash_seq_pkg::ST_ABORTED);
        read_back(a);
        read_back(17'h1ffff);
        // byte a is not blank, so the erase starts charging at byte 0; reset once it verifies
        p = flash_model_i.pulses;
        n = 0;
        @(posedge core_clk);
        {job_start, job_kind} <= {1'b1, flash_seq_pkg::JOB_ERASE};
        @(posedge core_clk);
        job_start <= 0;
        while (flash_model_i.cmd_q !== flash_seq_pkg::CMD_PROGRAM_VERIFY) begin
            @(posedge core_clk);
            n++;
            if (n > 4000) begin
                failures++;
                finish_test();
            end
        end
        // the verify read is over and the bus idle before the reset lands
        repeat (10) @(posedge core_clk);
        rstn <= 0;
        repeat (2) @(posedge core_clk);
        rstn <= 1;
        @(posedge core_clk);
        check("charge pulses", flash_model_i.pulses - p, 1);
        check("busy after reset", job_busy, 0);
        check("ce after reset", fl_ce_n, 1);
        ref_mem[0] = flash_seq_pkg::DATA_CHARGED;
        read_back(0);
        check("pulse ends", flash_model_i.bad, 0);
        check("pulse long", flash_model_i.min_pulse >= 10000.0, 1);
        finish_test();
    end
endmodule
